// File: dcd_decoder.sv
`timescale 1ns/100ps
module dcd_decoder
    import dcd_pkg::*;
#(
    parameter logic [15:0] REVISION = 16'h0100,
    parameter logic [11:0] FLASH_CTL_ADDR = 12'hFF0,
    parameter logic [7:0] MASS_ERASE = 8'hAA
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RSTN,
    // Open-drain debug serial pin.
    input wire logic DBG_PIN_I,
    output logic DBG_PIN_O,
    output logic DBG_PIN_OE,
    // Device state.
    input wire logic READ_PROTECT,
    input wire logic BRK_DECODE,
    input wire logic [15:0] PC_IN,
    input wire logic [7:0] STATUS_IN,
    output logic CPU_HALT,
    output logic [7:0] CTL_OUT,
    // Hand-off to neighbouring command executors.
    output dcd_cmd_t EXT_CMD,
    output dcd_byte_t EXT_RX,
    output logic EXT_RX_KEEP,
    input dcd_byte_t EXT_TX_IN,
    output logic EXT_TX_READY,
    input wire logic EXT_DONE,
    output logic EXT_ABORT
);

    // Commands that the read-protect option disables.
    function automatic logic is_prot(input logic [7:0] c);
        return c inside {8'h06, 8'h07, [8'h0A:8'h0D], [8'h10:8'h12]};
    endfunction

    // A low run longer than nine bit periods marks a break; a 00H character is exactly nine.
    function automatic logic [13:0] brk_lim(input logic [9:0] b);
        return {1'b0, b, 3'h0} + {4'h0, b};
    endfunction

    logic line;
    logic tx_start, tx_brk, tx_busy, tx_coll;
    logic [7:0] tx_data;
    logic [9:0] bit_len_q, bit_len_d;

    // Pin synchroniser and filter.
    dcd_sync u_sync (
        .clk(CLK),
        .rstn(RSTN),
        .d(DBG_PIN_I),
        .q(line)
    );

    // Response and break transmitter.
    dcd_tx u_tx (
        .clk(CLK),
        .rstn(RSTN),
        .line(line),
        .bit_len(bit_len_q),
        .start(tx_start),
        .data(tx_data),
        .breakpoint_instruction(tx_brk),
        .busy(tx_busy),
        .collide(tx_coll),
        .pin_oe(DBG_PIN_OE)
    );

    // Link receiver state.
    dcd_link_t link_q, link_d;
    logic [12:0] cnt_q, cnt_d;
    logic [3:0] bitn_q, bitn_d;
    logic [7:0] sh_q, sh_d;
    logic [13:0] low_q, low_d;
    dcd_byte_t rx_byte;
    logic link_err;

    // Auto-baud, character receiver and error detection.
    always_comb begin
        link_d = link_q;
        cnt_d = cnt_q;
        bit_len_d = bit_len_q;
        bitn_d = bitn_q;
        sh_d = sh_q;
        low_d = (line || tx_busy) ? 14'h0000 : ((low_q == 14'h3FFF) ? low_q : low_q + 14'h0001);
        rx_byte = '0;
        link_err = 1'b0;
        tx_brk = 1'b0;
        unique case (link_q)
            L_BAUD: begin
                low_d = 14'h0000;
                if (!line) begin
                    cnt_d = (cnt_q == 13'h1FFF) ? cnt_q : cnt_q + 13'h0001;
                end else if (cnt_q != 13'h0000) begin
                    // The low run of 80H is eight bit periods.
                    bit_len_d = (cnt_q[12:3] == 10'h000) ? 10'h001 : cnt_q[12:3]; // [RQ18]
                    cnt_d = 13'h0000;
                    link_d = L_IDLE;
                end
            end
            L_IDLE: begin
                // Own transmissions are not received.
                if (!line && !tx_busy) begin
                    cnt_d = {4'h0, bit_len_q[9:1]};
                    bitn_d = 4'h0;
                    link_d = L_BITS;
                end
            end
            L_BITS: begin
                if (cnt_q != 13'h0000) begin
                    cnt_d = cnt_q - 13'h0001;
                end else begin
                    cnt_d = {3'h0, bit_len_q - 10'h001};
                    bitn_d = bitn_q + 4'h1;
                    if (bitn_q == 4'h0 && line) begin
                        link_d = L_IDLE;
                    end else if (bitn_q == STOP_BIT) begin
                        link_d = L_IDLE;
                        if (line) begin
                            rx_byte = {1'b1, sh_q}; // [RQ17]
                        end else begin
                            link_err = 1'b1; // [RQ19]
                        end
                    end else if (bitn_q != 4'h0) begin
                        sh_d = {line, sh_q[7:1]}; // [RQ17]
                    end
                end
            end
            L_BREAK: begin
                // Held until our break ends and the host releases the line.
                if (cnt_q != 13'h0000) begin
                    cnt_d = cnt_q - 13'h0001;
                end else if (!tx_busy && line) begin
                    link_d = L_BAUD;
                end
            end
        endcase
        if (link_q != L_BAUD && link_q != L_BREAK && (tx_coll || low_q > brk_lim(bit_len_q))) begin
            link_err = 1'b1; // [RQ19]
        end
        if (link_err) begin
            link_d = L_BREAK; // [RQ19]
            cnt_d = 13'h0002;
            tx_brk = 1'b1;
            rx_byte = '0;
        end
    end

    // Register the link state.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            link_q <= L_BAUD;
            cnt_q <= 13'h0000;
            bit_len_q <= 10'h001;
            bitn_q <= 4'h0;
            sh_q <= 8'h00;
            low_q <= 14'h0000;
        end else begin
            link_q <= link_d;
            cnt_q <= cnt_d;
            bit_len_q <= bit_len_d;
            bitn_q <= bitn_d;
            sh_q <= sh_d;
            low_q <= low_d;
        end
    end

    // Command decoder state.
    dcd_cst_t cst_q, cst_d;
    logic [7:0] cmd_q, cmd_d, pay_q, pay_d;
    logic [1:0] need_q, need_d, rn_q, rn_d, idx_q, idx_d;
    logic [15:0] resp_q, resp_d;
    logic ok_q, ok_d;
    logic [11:0] addr_q, addr_d;
    dcd_cmd_t ext_cmd_q, ext_cmd_d;
    dcd_byte_t ext_rx_q, ext_rx_d;
    logic keep_q, keep_d, txr_q, txr_d, abort_q, abort_d;
    logic ctl_wr, cnt_wr, page_ok, is_reg;
    logic [15:0] wr_data;
    logic [7:0] ctl_q;
    logic [15:0] dcnt_q;

    // Decode commands, collect payloads and send responses.
    always_comb begin
        cst_d = cst_q;
        cmd_d = cmd_q;
        pay_d = pay_q;
        need_d = need_q;
        rn_d = rn_q;
        idx_d = idx_q;
        resp_d = resp_q;
        ok_d = ok_q;
        addr_d = addr_q;
        ext_cmd_d = '0;
        ext_rx_d = '0;
        keep_d = 1'b0;
        txr_d = 1'b0;
        abort_d = link_err;
        tx_start = 1'b0;
        tx_data = 8'h00;
        ctl_wr = 1'b0;
        cnt_wr = 1'b0;
        wr_data = 16'h0000;
        page_ok = !READ_PROTECT || addr_q[11:8] == UPPER_PAGE; // [RQ5] [RQ6]
        is_reg = cmd_q == CMD_REG_WR || cmd_q == CMD_REG_RD;
        unique case (cst_q)
            C_IDLE: begin
                if (rx_byte.valid) begin
                    cmd_d = rx_byte.data; // [RQ1]
                    unique case (rx_byte.data)
                        CMD_REV: begin
                            resp_d = REVISION; // [RQ7]
                            rn_d = 2'h2;
                            cst_d = C_RESP;
                        end
                        CMD_CNT_WR: begin
                            need_d = 2'h2;
                            cst_d = C_PAY;
                        end
                        CMD_STAT: begin
                            resp_d = {STATUS_IN, 8'h00}; // [RQ9]
                            rn_d = 2'h1;
                            cst_d = C_RESP;
                        end
                        CMD_CNT_RD: begin
                            resp_d = ctl_q[CTL_HALT] ? ~dcnt_q : ALL_ONES16; // [RQ10] [RQ11]
                            rn_d = 2'h2;
                            cst_d = C_RESP;
                        end
                        CMD_CTL_WR: begin
                            need_d = 2'h1;
                            cst_d = C_PAY;
                        end
                        CMD_CTL_RD: begin
                            resp_d = {ctl_q, 8'h00}; // [RQ14]
                            rn_d = 2'h1;
                            cst_d = C_RESP;
                        end
                        CMD_RSVD: begin
                            cst_d = C_IDLE; // [RQ21]
                        end
                        default: begin
                            if (rx_byte.data <= CMD_LAST) begin
                                // Gate by halt state and read protection.
                                ok_d = ctl_q[CTL_HALT] && !(READ_PROTECT && is_prot(rx_byte.data)); // [RQ2] [RQ3] [RQ4]
                                ext_cmd_d = {1'b1, ok_d, rx_byte.data};
                                idx_d = 2'h0;
                                cst_d = C_EXT;
                            end
                        end
                    endcase
                end
            end
            C_PAY: begin
                if (rx_byte.valid) begin
                    pay_d = rx_byte.data;
                    need_d = need_q - 2'h1;
                    if (need_q == 2'h1) begin
                        cst_d = C_IDLE;
                        wr_data = {pay_q, rx_byte.data}; // [RQ16]
                        if (cmd_q == CMD_CNT_WR) begin
                            cnt_wr = ctl_q[CTL_HALT]; // [RQ8]
                        end else begin
                            ctl_wr = 1'b1; // [RQ12]
                        end
                    end
                end
            end
            C_RESP: begin
                if (!tx_busy) begin
                    tx_start = 1'b1;
                    tx_data = resp_q[15:8]; // [RQ16]
                    resp_d = {resp_q[7:0], 8'h00};
                    rn_d = rn_q - 2'h1;
                    if (rn_q == 2'h1) begin
                        cst_d = C_IDLE;
                    end
                end
            end
            C_EXT: begin
                // Every payload byte is forwarded so the stream stays aligned.
                if (rx_byte.valid) begin
                    ext_rx_d = rx_byte; // [RQ22]
                    keep_d = ok_q;
                    if (is_reg) begin
                        idx_d = (idx_q == 2'h3) ? idx_q : idx_q + 2'h1;
                        if (idx_q == 2'h0) begin
                            addr_d[11:8] = rx_byte.data[3:0];
                        end else if (idx_q == 2'h1) begin
                            addr_d[7:0] = rx_byte.data;
                        end else if (idx_q == 2'h3 && cmd_q == CMD_REG_WR) begin
                            addr_d = addr_q + 12'h001;
                            keep_d = ok_q && page_ok && !(READ_PROTECT && addr_q == FLASH_CTL_ADDR
                                && rx_byte.data != MASS_ERASE); // [RQ5]
                        end
                    end
                end
                if (EXT_TX_IN.valid && !tx_busy && !txr_q) begin
                    tx_start = 1'b1;
                    txr_d = 1'b1;
                    tx_data = (ok_q && (!is_reg || page_ok)) ? EXT_TX_IN.data : ALL_ONES8; // [RQ6]
                    if (is_reg && idx_q == 2'h3) begin
                        addr_d = addr_q + 12'h001;
                    end
                end
                if (EXT_DONE) begin
                    cst_d = C_IDLE;
                end
            end
        endcase
        if (link_err) begin
            cst_d = C_IDLE; // [RQ19]
            tx_start = 1'b0;
        end
    end

    // Register the decoder state.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cst_q <= C_IDLE;
            cmd_q <= 8'h00;
            pay_q <= 8'h00;
            need_q <= 2'h0;
            rn_q <= 2'h0;
            idx_q <= 2'h0;
            resp_q <= 16'h0000;
            ok_q <= 1'b0;
            addr_q <= 12'h000;
            ext_cmd_q <= '0;
            ext_rx_q <= '0;
            keep_q <= 1'b0;
            txr_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            cst_q <= cst_d;
            cmd_q <= cmd_d;
            pay_q <= pay_d;
            need_q <= need_d;
            rn_q <= rn_d;
            idx_q <= idx_d;
            resp_q <= resp_d;
            ok_q <= ok_d;
            addr_q <= addr_d;
            ext_cmd_q <= ext_cmd_d;
            ext_rx_q <= ext_rx_d;
            keep_q <= keep_d;
            txr_q <= txr_d;
            abort_q <= abort_d;
        end
    end

    // Control register, debug counter and reset strap.
    logic [7:0] ctl_d;
    logic [15:0] dcnt_d;
    logic halt_prev_q, halt_prev_d, set_halt, running;
    logic [2:0] strap_q, strap_d;

    always_comb begin
        ctl_d = ctl_q;
        dcnt_d = dcnt_q;
        strap_d = strap_q;
        set_halt = 1'b0;
        running = !ctl_q[CTL_HALT];
        halt_prev_d = ctl_q[CTL_HALT];
        // A low pin shortly after reset release enters halt.
        if (strap_q != STRAP_DELAY) begin
            strap_d = strap_q + 3'h1;
            if (strap_q == STRAP_DELAY - 3'h1 && !line) begin
                set_halt = 1'b1;
            end
        end
        if (cnt_wr) begin
            dcnt_d = wr_data;
        end else if (halt_prev_q && running && !ctl_q[CTL_BRKPC] && !ctl_q[CTL_BRKZRO]) begin
            dcnt_d = ALL_ONES16; // [RQ15]
        end else if (running && !ctl_q[CTL_BRKPC] && dcnt_q != CNT_RESET) begin
            dcnt_d = dcnt_q - 16'h0001; // [RQ15]
        end
        if (running && ctl_q[CTL_BRKZRO] && !ctl_q[CTL_BRKPC] && dcnt_q == 16'h0001) begin
            set_halt = 1'b1; // [RQ15]
        end
        if (running && ctl_q[CTL_BRKPC] && PC_IN == dcnt_q) begin
            set_halt = 1'b1; // [RQ15]
        end
        if (running && BRK_DECODE && ctl_q[CTL_BRKEN] && !ctl_q[CTL_BRKLOOP]) begin
            set_halt = 1'b1;
        end
        if (ctl_wr) begin
            ctl_d = wr_data[7:0]; // [RQ12]
            ctl_d[CTL_RSVD] = 1'b0;
            if (READ_PROTECT && ctl_q[CTL_HALT]) begin
                ctl_d[CTL_HALT] = 1'b1; // [RQ13]
            end
        end
        if (set_halt) begin
            ctl_d[CTL_HALT] = 1'b1;
        end
    end

    // Register the device state.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctl_q <= CTL_RESET;
            dcnt_q <= CNT_RESET;
            halt_prev_q <= 1'b0;
            strap_q <= 3'h0;
        end else begin
            ctl_q <= ctl_d;
            dcnt_q <= dcnt_d;
            halt_prev_q <= halt_prev_d;
            strap_q <= strap_d;
        end
    end

    // Outputs.
    assign CPU_HALT = ctl_q[CTL_HALT]; // [RQ20]
    assign CTL_OUT = ctl_q;
    assign DBG_PIN_O = 1'b0;
    assign EXT_CMD = ext_cmd_q;
    assign EXT_RX = ext_rx_q;
    assign EXT_RX_KEEP = keep_q;
    assign EXT_TX_READY = txr_q;
    assign EXT_ABORT = abort_q;
endmodule

// File: dcd_pkg.sv
// How it works
// [RQ1] Transaction starts with one command byte.
// [RQ2] Outside halt only revision, status, control commands.
// [RQ3] In halt every assigned command is available.
// [RQ4] Read protect blocks PC, memory, step commands.
// [RQ5] Protected register writes: upper page, mass erase.
// [RQ6] Protected register reads: upper page only.
// [RQ7] Revision read returns major then minor byte.
// [RQ8] Counter write discarded outside halt.
// [RQ9] Status read returns one status byte.
// [RQ10] Counter read returns complement, high byte first.
// [RQ11] Counter read outside halt returns all ones.
// [RQ12] Control write loads one byte.
// [RQ13] Read protect: halt bit set, never cleared.
// [RQ14] Control read returns control register byte.
// [RQ15] Counter counts cycles or raises breakpoints.
// [RQ16] Multi-byte values travel high byte first.
// [RQ17] Characters: start, eight data LSB first, stop.
// [RQ18] First character 80H sets the bit rate.
// [RQ19] Errors abort, send long break, rebaud.
// [RQ20] Halt bit stops the processor fetching.
// [RQ21] Reserved codes are ignored silently.
// [RQ22] Unavailable commands still consume their payload.
package dcd_pkg;

    // Command codes.
    localparam logic [7:0] CMD_REV = 8'h00;
    localparam logic [7:0] CMD_CNT_WR = 8'h01;
    localparam logic [7:0] CMD_STAT = 8'h02;
    localparam logic [7:0] CMD_CNT_RD = 8'h03;
    localparam logic [7:0] CMD_CTL_WR = 8'h04;
    localparam logic [7:0] CMD_CTL_RD = 8'h05;
    localparam logic [7:0] CMD_REG_WR = 8'h08;
    localparam logic [7:0] CMD_REG_RD = 8'h09;
    localparam logic [7:0] CMD_RSVD = 8'h0F;
    localparam logic [7:0] CMD_LAST = 8'h12;

    // Control register field positions and reset value.
    localparam int CTL_HALT = 7;
    localparam int CTL_BRKEN = 6;
    localparam int CTL_BRKLOOP = 4;
    localparam int CTL_BRKPC = 3;
    localparam int CTL_BRKZRO = 2;
    localparam int CTL_RSVD = 1;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // Values and counts.
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] ALL_ONES16 = 16'hFFFF;
    localparam logic [7:0] ALL_ONES8 = 8'hFF;
    localparam logic [3:0] UPPER_PAGE = 4'hF;
    localparam int BREAK_CYCLES = 4096;
    localparam logic [12:0] BREAK_LOAD = 13'(BREAK_CYCLES - 1);
    localparam logic [2:0] STRAP_DELAY = 3'h5;
    localparam logic [3:0] STOP_BIT = 4'h9;

    // Link and command state machines.
    typedef enum logic [3:0] {
        L_BAUD = 4'b0001,
        L_IDLE = 4'b0010,
        L_BITS = 4'b0100,
        L_BREAK = 4'b1000
    } dcd_link_t;

    typedef enum logic [3:0] {
        C_IDLE = 4'b0001,
        C_PAY = 4'b0010,
        C_RESP = 4'b0100,
        C_EXT = 4'b1000
    } dcd_cst_t;

    // One byte with its strobe.
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } dcd_byte_t;

    // Command handed to a neighbouring executor.
    typedef struct packed {
        logic valid;
        logic ok;
        logic [7:0] code;
    } dcd_cmd_t;

endpackage

// File: dcd_sync.sv
`timescale 1ns/100ps
module dcd_sync
    import dcd_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Raw pin and filtered level.
    input wire logic d,
    output logic q
);
    logic [2:0] sh_q;
    logic [2:0] sh_d;
    logic q_q;
    logic q_d;

    // The level changes only once the second and third stages agree.
    always_comb begin
        sh_d = {sh_q[1:0], d};
        q_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : q_q;
    end

    // The idle line is high, so every stage resets high.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sh_q <= 3'h7;
            q_q <= 1'b1;
        end else begin
            sh_q <= sh_d;
            q_q <= q_d;
        end
    end

    assign q = q_q;
endmodule

// File: dcd_tx.sv
`timescale 1ns/100ps
module dcd_tx
    import dcd_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Control.
    input wire logic line,
    input wire logic [9:0] bit_len,
    input wire logic start,
    input wire logic [7:0] data,
    input wire logic breakpoint_instruction,
    // Status and pin.
    output logic busy,
    output logic collide,
    output logic pin_oe
);
    logic busy_q, busy_d, brk_q, brk_d, coll_q, coll_d, oe_q, oe_d;
    logic [9:0] sh_q, sh_d;
    logic [3:0] n_q, n_d;
    logic [12:0] t_q, t_d;

    // Serialiser; a break request overrides any character in flight.
    always_comb begin
        busy_d = busy_q;
        brk_d = brk_q;
        oe_d = oe_q;
        sh_d = sh_q;
        n_d = n_q;
        t_d = t_q;
        coll_d = 1'b0;
        if (breakpoint_instruction) begin
            brk_d = 1'b1;
            busy_d = 1'b1;
            oe_d = 1'b1;
            t_d = BREAK_LOAD; // [RQ19]
        end else if (start && !busy_q) begin
            sh_d = {1'b1, data, 1'b0}; // [RQ17]
            n_d = 4'h0;
            t_d = {3'h0, bit_len - 10'h001};
            busy_d = 1'b1;
            oe_d = 1'b1;
        end else if (busy_q) begin
            if (t_q != 13'h0000) begin
                t_d = t_q - 13'h0001;
                // The filtered wire lags by four cycles, so a released bit is judged at its end.
                if (!brk_q && t_q == 13'h0001 && sh_q[0] && !line) begin
                    coll_d = 1'b1; // [RQ19]
                end
            end else if (brk_q || n_q == STOP_BIT) begin
                busy_d = 1'b0;
                brk_d = 1'b0;
                oe_d = 1'b0;
            end else begin
                n_d = n_q + 4'h1;
                sh_d = {1'b1, sh_q[9:1]};
                oe_d = !sh_q[1];
                t_d = {3'h0, bit_len - 10'h001};
            end
        end
    end

    // Register the serialiser state.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_q <= 1'b0;
            brk_q <= 1'b0;
            coll_q <= 1'b0;
            oe_q <= 1'b0;
            sh_q <= 10'h3FF;
            n_q <= 4'h0;
            t_q <= 13'h0000;
        end else begin
            busy_q <= busy_d;
            brk_q <= brk_d;
            coll_q <= coll_d;
            oe_q <= oe_d;
            sh_q <= sh_d;
            n_q <= n_d;
            t_q <= t_d;
        end
    end

    assign busy = busy_q;
    assign collide = coll_q;
    assign pin_oe = oe_q;
endmodule

// File: dcd_host.sv
`timescale 1ns/100ps
module dcd_host (
    // Clock and wire level.
    input wire logic clk,
    input wire logic line,
    // High pulls the open-drain wire low.
    output logic pull
);
    localparam int BIT = 8;

    initial pull = 1'b0;

    // Sends start, data least significant first, stop held for hold cycles.
    task automatic send(input logic [7:0] b, input int hold);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            pull <= ~f[i];
            repeat (i < 9 ? BIT : hold) @(posedge clk);
        end
    endtask

    // Receives one character; ok stays low if no start bit came in time.
    task automatic recv(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        while (line && n < 200) begin
            @(posedge clk);
            n++;
        end
        ok = !line;
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            b[i] = line;
        end
        repeat (BIT) @(posedge clk);
    endtask
endmodule

// File: dcd_decoder_assertions.sv
`timescale 1ns/100ps
module dcd_decoder_assertions
    import dcd_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RSTN,
    // Watched ports.
    input wire logic READ_PROTECT,
    input wire logic CPU_HALT,
    input wire logic [7:0] CTL_OUT,
    input dcd_cmd_t EXT_CMD
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // Halt output, control bits and command hand-off gating.
    AST_HALT_BIT: assert property (CPU_HALT == CTL_OUT[CTL_HALT]) else $error("halt differs");
    AST_RSVD_ZERO: assert property (!CTL_OUT[CTL_RSVD]) else $error("reserved bit set");
    AST_PROT_KEEP: assert property (READ_PROTECT && $past(READ_PROTECT && CPU_HALT) |-> CPU_HALT)
        else $error("halt cleared under protection");
    AST_CMD_PULSE: assert property (EXT_CMD.valid |=> !EXT_CMD.valid) else $error("command not a pulse");
    AST_NO_RSVD: assert property (EXT_CMD.valid |-> EXT_CMD.code != CMD_RSVD && EXT_CMD.code <= CMD_LAST)
        else $error("reserved code passed on");
    AST_HALT_GATE: assert property (EXT_CMD.valid && !CPU_HALT |-> !EXT_CMD.ok) else $error("ok unhalted");
    AST_HALT_OPEN: assert property (EXT_CMD.valid && CPU_HALT && !READ_PROTECT |-> EXT_CMD.ok)
        else $error("refused in halt");
    AST_PROT_BLOCK: assert property (EXT_CMD.valid && READ_PROTECT
        && EXT_CMD.code inside {8'h06, 8'h07, [8'h0A:8'h0D], [8'h10:8'h12]} |-> !EXT_CMD.ok)
        else $error("allowed under protection");
endmodule

bind dcd_decoder dcd_decoder_assertions chk (.CLK(CLK), .RSTN(RSTN), .READ_PROTECT(READ_PROTECT),
    .CPU_HALT(CPU_HALT), .CTL_OUT(CTL_OUT), .EXT_CMD(EXT_CMD));

// File: debug_command_decoder_bench.sv
`timescale 1ns/100ps
module debug_command_decoder_bench;
    import dcd_pkg::*;
    logic clk = 1'b0;
    logic rstn, rp, done, oe, pull, o, last_ok;
    logic [7:0] stat, ctl;
    logic [15:0] pc;
    dcd_cmd_t cmd;
    dcd_byte_t tx;
    wire logic line;
    int n_errors = 0;
    int compares = 0;
    int seed = 11968;
    int ncmd = 0;

    // Open-drain wire with pull-up.
    assign line = ~(oe | pull);

    dcd_decoder #(.REVISION(16'h5A3C)) dut (.CLK(clk), .RSTN(rstn), .DBG_PIN_I(line), .DBG_PIN_O(o),
        .DBG_PIN_OE(oe), .READ_PROTECT(rp), .BRK_DECODE(1'b0), .PC_IN(pc), .STATUS_IN(stat), .CPU_HALT(),
        .CTL_OUT(ctl), .EXT_CMD(cmd), .EXT_RX(), .EXT_RX_KEEP(), .EXT_TX_IN(tx), .EXT_TX_READY(),
        .EXT_DONE(done), .EXT_ABORT());
    dcd_host host (.clk(clk), .line(line), .pull(pull));

    // Clock of 8 ns period.
    initial forever #4 clk = ~clk;

    // Counts hand-off pulses and keeps the last permission.
    always @(posedge clk) if (cmd.valid) begin
        ncmd <= ncmd + 1;
        last_ok <= cmd.ok;
    end

    task automatic complete_run();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Sends a code and collects n response bytes, last byte in the low half.
    task automatic rd(input logic [7:0] c, input int n, output logic [15:0] v);
        logic [7:0] b;
        logic ok;
        host.send(c, 2);
        v = 16'h0000;
        for (int i = 0; i < n; i++) begin
            host.recv(b, ok);
            check("response start", 16'h0001, {15'h0000, ok});
            if (!ok) complete_run();
            v = {v[7:0], b};
        end
        repeat (8) @(posedge clk);
    endtask

    // Sends a code and n payload bytes, high byte first.
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
        host.send(c, 12);
        for (int i = n - 1; i >= 0; i--) host.send(d[8*i+:8], 12);
        repeat (8) @(posedge clk);
    endtask

    // Sends a handed-off code, checks its permission and closes it.
    task automatic ext(input logic [7:0] c, input logic e);
        int k0;
        k0 = ncmd;
        host.send(c, 12);
        for (int k = 0; k < 50 && ncmd == k0; k++) @(posedge clk);
        check("hand-off", 16'h0001, 16'(ncmd - k0));
        if (ncmd == k0) complete_run();
        check("permission", {15'h0000, e}, {15'h0000, last_ok});
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    initial begin
        logic [15:0] v, w;
        logic [7:0] r;
        rstn = 1'b0;
        rp = 1'b0;
        done = 1'b0;
        tx = '0;
        stat = 8'($random(seed));
        pc = 16'($random(seed));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (10) @(posedge clk);
        check("control after reset", 16'h0000, {8'h00, ctl});
        host.send(8'h80, 12);
        repeat (8) @(posedge clk);
        rd(CMD_REV, 2, v);
        check("revision", 16'h5A3C, v);
        rd(CMD_STAT, 1, v);
        check("status", {8'h00, stat}, v);
        rd(CMD_CNT_RD, 2, v);
        check("counter outside halt", ALL_ONES16, v);
        ext(8'h06, 1'b0);
        $display("test running state done");
        wr(CMD_CTL_WR, 16'h0080, 1);
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed));
            wr(CMD_CNT_WR, v, 2);
            rd(CMD_CNT_RD, 2, w);
            check("counter", ~v, w);
            r = 8'($random(seed));
            wr(CMD_CTL_WR, {8'h00, 1'b1, r[6:1], 1'b0}, 1);
            rd(CMD_CTL_RD, 1, w);
            check("control", {8'h00, 1'b1, r[6:2], 2'b00}, w);
        end
        $display("test halt state done");
        for (int p = 0; p < 2; p++) begin
            rp <= p[0];
            @(posedge clk);
            for (int c = 6; c <= 18; c++) begin
                if (c != 15) ext(8'(c), !(p == 1 && !(c inside {8, 9, 14})));
            end
        end
        wr(CMD_CTL_WR, 16'h0000, 1);
        rd(CMD_CTL_RD, 1, v);
        check("halt under protection", 16'h0001, {15'h0000, v[7]});
        foreach (r[i]) begin
            host.send(i == 0 ? CMD_RSVD : (i == 1 ? 8'h13 : 8'hFF), 12);
            for (int k = 0; k < 30; k++) begin
                @(posedge clk);
                check("silence", 16'h0000, {15'h0000, oe});
            end
        end
        rd(CMD_STAT, 1, v);
        check("status after reserved", {8'h00, stat}, v);
        $display("test protection done");
        complete_run();
    end
endmodule
